// file: dv/mode_cfg_sva.sv
// Purpose: port checker for the mode and config block
// Assumes: one clock, hresetn async active low
// Notes:   bound into the block below
`timescale 1ns/1ps
`default_nettype none
module mode_cfg_sva (
  // bus side
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  // mode pins and radio
  input wire logic        mode_select_low,
  input wire logic        mode_select_high,
  input wire logic        status_ready,
  input wire logic [7:0]  radio_tx_data,
  input wire logic        radio_tx_valid,
  input wire logic        radio_tx_ready,
  input wire logic        radio_wake,
  input wire logic        radio_tx_enable,
  input wire logic        radio_rx_enable
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // read address phase seen on the bus
  wire rd_phase = hsel && htrans[1] && !hwrite && hready;
  wire lo = mode_select_low;
  wire hi = mode_select_high;
  chk_sleep_radio: assert property ((!lo && !hi)[*3] |-> !radio_tx_enable)
    else $error("radio on in sleep");
  chk_sleep_status: assert property ((!lo && !hi)[*3] |-> !status_ready)
    else $error("status high in sleep");
  chk_cfg_radio: assert property ((lo && !hi)[*3] |-> !radio_rx_enable)
    else $error("radio on in config");
  // cycles with both selects on, saturating at 16
  logic [4:0] normal_cnt_reg;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      normal_cnt_reg <= 5'h00;
    else if (!(lo && hi))
      normal_cnt_reg <= 5'h00;
    else if (!normal_cnt_reg[4])
      normal_cnt_reg <= normal_cnt_reg + 5'h01;
  chk_normal_radio: assert property (normal_cnt_reg[4] |->
    radio_tx_enable) else $error("radio off in normal mode");
  chk_wake_mode: assert property (radio_wake |-> $past(hi && !lo, 2))
    else $error("wake code outside wake mode");
  chk_tx_hold: assert property (radio_tx_valid && !radio_tx_ready |=>
    radio_tx_valid && $stable(radio_tx_data)) else $error("tx byte dropped");
  chk_en_pair: assert property (radio_tx_enable == radio_rx_enable)
    else $error("radio enables differ");
  chk_read_hold: assert property (!rd_phase |=> $stable(hrdata))
    else $error("read data moved");
  cover property ($rose(status_ready));
  cover property (radio_wake ##[1:60] radio_tx_valid);
  cover property (radio_tx_valid && radio_tx_ready);
endmodule // mode_cfg_sva
bind mode_select_config_commands mode_cfg_sva i_sva (.*);
`default_nettype wire

// file: dv/mode_select_config_commands_test.sv
// Purpose: bench for the mode and config block
// Assumes: 10 clocks per serial bit
// Notes:   bus master and host drive on rising edges
`timescale 1ns/1ps
`default_nettype none
module mode_select_config_commands_test;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, radio_rx_valid = 0;
  logic mode_select_low = 1, mode_select_high = 0, radio_tx_ready = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic [31:0] haddr = 0, hwdata = 0, q;
  logic [7:0] radio_rx_data = 0;
  wire hreadyout, hresp, status_ready, uart_txd, uart_rxd, radio_tx_valid;
  wire radio_wake, radio_tx_enable, radio_rx_ready, radio_rx_enable;
  wire [31:0] hrdata;
  wire [7:0] radio_tx_data;
  int fails = 0, comparisons = 0, n;
  always #5 hclk = ~hclk;
  mode_select_config_commands #(.CLK_HZ(96000), .WAKE_CYCLES(20)) i_dut (
    .hready(hreadyout), .*);
  uart_host #(.BIT(10)) i_host (.hclk(hclk), .txd(uart_rxd), .rxd(uart_txd));
  task end_sim();
    $display("counts: %0d comparisons, %0d fails", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one bounded clock step
  task tick();
    @(posedge hclk);
    n++;
    if (n > 5000)
    begin
      $display("CHECK FAILED %0t wait ran out", $time);
      fails++;
      end_sim();
    end
  endtask
  task chk(input logic [31:0] g, e, input string m);
    comparisons++;
    if (g !== e)
    begin
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
      fails++;
    end
  endtask
  // single word transfer, data taken at the data phase edge
  task ahb(input logic w, input logic [31:0] a, d);
    hsel <= 1;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= a;
    n = 0;
    tick();
    while (hreadyout !== 1'b1) tick();
    hsel <= 0;
    htrans <= 0;
    hwdata <= d;
    tick();
    while (hreadyout !== 1'b1) tick();
    q = hrdata;
    chk(hresp, 0, "resp okay");
  endtask
  // send a command and compare the whole reply
  task cmd(input logic [7:0] c[$], r[$]);
    i_host.rx_q.delete();
    foreach (c[i]) i_host.send(c[i]);
    n = 0;
    while (i_host.rx_q.size() < r.size()) tick();
    foreach (r[i]) chk(i_host.rx_q[i], r[i], "reply byte");
    repeat (30) @(posedge hclk);
  endtask
  task mode(input logic lo, hi);
    mode_select_low <= lo;
    mode_select_high <= hi;
    repeat (3) @(posedge hclk);
    n = 0;
    while (status_ready !== 1'b1 && (lo | hi)) tick();
  endtask
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    mode(1, 0);
    ahb(0, 32'h04, 0);
    chk(q[1:0], 2, "config mode");
    ahb(1, 32'h00, 1);
    ahb(0, 32'h00, 0);
    chk(q, 1, "ctrl");
    ahb(0, 32'h40, 0);
    chk(q, 0, "unmapped");
    cmd('{8'hc0, 0, 4, 8'h12, 8'h34, 0, 8'h61}, '{8'hc1, 0, 4, 8'h12, 8'h34,
      0, 8'h61});
    cmd('{8'hc1, 0, 4}, '{8'hc1, 0, 4, 8'h12, 8'h34, 0, 8'h61});
    cmd('{8'hc2, 5, 1, 9}, '{8'hc1, 5, 1, 9});
    cmd('{8'hcf, 8'hcf, 8'hc1, 5, 1}, '{8'hcf, 8'hcf, 8'hc1, 5, 1, 9});
    cmd('{8'hc0, 0, 0}, '{8'hee, 8'hee, 8'hee});
    ahb(0, 32'h08, 0);
    chk(q, 32'h61003412, "bytes 3..0");
    ahb(0, 32'h0c, 0);
    chk(q, 32'h00000900, "bytes 7..4");
    $display("test config done");
    mode(0, 0);
    chk(status_ready, 0, "sleep status");
    mode_select_low <= 1;
    mode_select_high <= 1;
    repeat (3) @(posedge hclk);
    chk(status_ready, 0, "reloading");
    mode(1, 1);
    ahb(0, 32'h04, 0);
    chk(q[1:0], 0, "normal mode");
    ahb(0, 32'h0c, 0);
    chk(q, 0, "temp lost");
    ahb(0, 32'h08, 0);
    chk(q, 32'h61003412, "kept");
    i_host.send(8'h5a);
    n = 0;
    while (radio_tx_valid !== 1'b1) tick();
    repeat (3) @(posedge hclk);
    chk(radio_tx_data, 8'h5a, "radio tx");
    radio_tx_ready <= 1;
    i_host.rx_q.delete();
    radio_rx_data <= 8'ha5;
    radio_rx_valid <= 1;
    n = 0;
    tick();
    while (radio_rx_ready !== 1'b1) tick();
    radio_rx_valid <= 0;
    while (i_host.rx_q.size() < 1) tick();
    chk(i_host.rx_q[0], 8'ha5, "radio rx");
    $display("test normal done");
    mode(0, 1);
    ahb(0, 32'h04, 0);
    chk(q[1:0], 1, "wake mode");
    i_host.send(8'h3c);
    n = 0;
    while (radio_wake !== 1'b1) tick();
    chk(radio_tx_valid, 0, "wake first");
    while (radio_tx_valid !== 1'b1) tick();
    chk(radio_tx_data, 8'h3c, "wake tx");
    $display("test wake done");
    end_sim();
  end
endmodule // mode_select_config_commands_test
`default_nettype wire

// file: dv/uart_host.sv
// Purpose: host serial port model, 8N1
// Assumes: BIT clocks per bit cell
// Notes:   heard bytes queue up in rx_q
`timescale 1ns/1ps
`default_nettype none
module uart_host #(parameter int BIT = 10) (
  // clock and serial lines
  input  wire logic hclk,
  output var  logic txd,
  input  wire logic rxd
);
  logic [7:0] rx_q[$]; // bytes heard from the device
  initial txd = 1'b1;
  // start low, lsb first, stop high
  task send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge hclk) txd <= f[i];
      repeat (BIT - 1) @(posedge hclk);
    end
  endtask
  // sample mid cell, then skip stop bit
  always
  begin : rx
    logic [7:0] b;
    @(negedge rxd);
    repeat (BIT / 2) @(posedge hclk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge hclk);
      b[i] = rxd;
    end
    repeat (BIT) @(posedge hclk);
    rx_q.push_back(b);
  end
endmodule // uart_host
`default_nettype wire

// file: hw/byte_fifo.v
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: single clock, asynchronous active-low reset
// Notes:   depth must be a power of two; full refuses writes
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             hclk,
  input  wire             hresetn,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];  // storage words
  reg [AW-1:0]    wr_ptr_reg;           // write pointer
  reg [AW-1:0]    rd_ptr_reg;           // read pointer
  reg [AW:0]      count_reg;            // words held
  wire            push;                 // word accepted
  wire            pop;                  // word taken

  // honest full and empty flags
  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage write, no reset needed on data
  always @(posedge hclk)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data;
  end

  // pointers and occupancy
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      // simultaneous push and pop leave the count alone
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule // byte_fifo
`default_nettype wire

// file: hw/mode_cfg_consts.vh
// Purpose: shared constants of the mode select and configuration block
// Assumes: included by its bare name from the mode select design file only
// Notes:   definitions only, no logic
`ifndef MODE_CFG_CONSTS_VH
`define MODE_CFG_CONSTS_VH

// clock rate and wake-up preamble time
`define CLK_HZ          100000000
`define WAKE_US         1000

// command framing bytes
`define CMD_WRITE       8'hc0
`define CMD_READ        8'hc1
`define CMD_TEMP        8'hc2
`define CMD_PREFIX      8'hcf
`define REPLY_HDR       8'hc1
`define ERR_BYTE        8'hee
`define ERR_LEN         8'h03

// configuration byte store
`define REG_COUNT       8
`define REG_COUNT_W     9'h008
`define SERIAL_REG      3'h3
`define BAUD_MSB        7
`define BAUD_LSB        5
`define BAUD_CFG_SEL    3'b011
`define DEF_ADDR_HI     8'h00
`define DEF_ADDR_LO     8'h00
`define DEF_NETWORK_IDENTIFIER       8'h00
`define DEF_SERIAL_AIR  8'h62

// operating modes
`define MODE_NORMAL     2'd0
`define MODE_WAKE       2'd1
`define MODE_CONFIG     2'd2
`define MODE_SLEEP      2'd3

// bus register byte offsets
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_CONFIG_LO   8'h08
`define OFS_CONFIG_HI   8'h0c

// host-to-radio buffer
`define FIFO_DEPTH      8
`define FIFO_AW         3

`endif

// file: hw/mode_select_config_commands.v
// Purpose: mode selection, serial config commands and radio data path
// Assumes: pins synchronous to hclk; AHB-Lite single-word slave
// Notes:   Function
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "mode_cfg_consts.vh"
module mode_select_config_commands #(
  parameter CLK_HZ      = `CLK_HZ,
  parameter WAKE_CYCLES = `WAKE_US * (`CLK_HZ / 1000000)
) (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  // mode pins and status
  input  wire        mode_select_low,
  input  wire        mode_select_high,
  output reg         status_ready,
  // host serial port
  input  wire        uart_rxd,
  output reg         uart_txd,
  // radio transmit stream
  output reg  [7:0]  radio_tx_data,
  output reg         radio_tx_valid,
  input  wire        radio_tx_ready,
  output reg         radio_wake,
  output reg         radio_tx_enable,
  // radio receive stream
  input  wire [7:0]  radio_rx_data,
  input  wire        radio_rx_valid,
  output reg         radio_rx_ready,
  output reg         radio_rx_enable
);
  // parser states
  localparam P_IDLE = 3'd0;
  localparam P_PRE2 = 3'd1;
  localparam P_HDR  = 3'd2;
  localparam P_ADDR = 3'd3;
  localparam P_LEN  = 3'd4;
  localparam P_DATA = 3'd5;
  localparam P_WAIT = 3'd6;

  reg  [7:0]  live_reg [0:`REG_COUNT-1];  // working configuration
  reg  [7:0]  save_reg [0:`REG_COUNT-1];  // kept configuration
  reg  [1:0]  mode_reg;                   // decoded mode
  reg         reload_reg;                 // reload in progress
  reg  [2:0]  reload_idx_reg;             // byte being reloaded
  reg         sender_reg;                 // wake sender enable
  reg         ahb_wr_reg;                 // pending bus write
  reg  [7:0]  ahb_addr_reg;               // pending bus address
  reg         rxd_prev_reg;               // line for start edge
  reg         rx_busy_reg;                // receiver framing
  reg  [19:0] rx_cnt_reg;                 // receiver bit timer
  reg  [3:0]  rx_bit_reg;                 // receiver bit index
  reg  [7:0]  rx_sh_reg;                  // receiver shifter
  reg         rx_done_reg;                // byte received pulse
  reg         tx_busy_reg;                // transmitter framing
  reg  [19:0] tx_cnt_reg;                 // transmitter bit timer
  reg  [3:0]  tx_bit_reg;                 // transmitter bit index
  reg  [9:0]  tx_sh_reg;                  // transmitter shifter
  reg  [2:0]  p_state_reg;                // command parser state
  reg         p_pfx_reg;                  // prefixed command
  reg  [7:0]  p_cmd_reg;                  // command byte
  reg  [7:0]  p_addr_reg;                 // start address
  reg  [7:0]  p_len_reg;                  // byte count
  reg  [7:0]  p_cnt_reg;                  // data bytes taken
  reg         r_act_reg;                  // reply in progress
  reg         r_err_reg;                  // reply is error form
  reg  [7:0]  r_idx_reg;                  // reply byte index
  reg  [7:0]  r_tot_reg;                  // reply length
  reg         woken_reg;                  // wake preamble done
  reg  [31:0] wake_cnt_reg;               // wake preamble timer
  wire [1:0]  mode_next;                  // mode from pins
  wire        awake;                      // radio modes usable
  wire [19:0] bit_len;                    // active bit period
  wire        fifo_in_ready;              // buffer has room
  wire        fifo_out_valid;             // buffer has a byte
  wire [7:0]  fifo_out_data;              // buffered byte
  wire        fifo_pop;                   // radio takes a byte
  wire        send_ok;                    // radio send allowed
  wire        rx_take;                    // radio byte accepted
  wire        cfg_rx;                     // command byte arrives
  wire [8:0]  span;                       // address plus length
  integer     i;

  // bit period in clocks for a baud selection
  function [19:0] bit_cycles;
    input [2:0] sel;
    reg [31:0] rate;
    reg [31:0] q;
    begin
      case (sel)
        3'd0:    rate = 32'd1200;
        3'd1:    rate = 32'd2400;
        3'd2:    rate = 32'd4800;
        3'd3:    rate = 32'd9600;
        3'd4:    rate = 32'd19200;
        3'd5:    rate = 32'd38400;
        3'd6:    rate = 32'd57600;
        default: rate = 32'd115200;
      endcase
      q = CLK_HZ / rate;
      bit_cycles = q[19:0];
    end
  endfunction

  // reset value of each configuration byte
  function [7:0] def_val;
    input [2:0] idx;
    begin
      case (idx)
        3'd0:    def_val = `DEF_ADDR_HI;
        3'd1:    def_val = `DEF_ADDR_LO;
        3'd2:    def_val = `DEF_NETWORK_IDENTIFIER;
        3'd3:    def_val = `DEF_SERIAL_AIR;
        default: def_val = 8'h00;
      endcase
    end
  endfunction

  // byte of the reply at a given position
  function [7:0] reply_byte;
    input [7:0] idx;
    reg   [7:0] j;
    reg   [7:0] k;
    begin
      j = p_pfx_reg ? idx - 8'd2 : idx;
      k = p_addr_reg + j - 8'd3;
      if (p_pfx_reg && idx < 8'd2)
        reply_byte = `CMD_PREFIX;
      else if (r_err_reg)
        reply_byte = `ERR_BYTE;
      else if (j == 8'd0)
        reply_byte = `REPLY_HDR;
      else if (j == 8'd1)
        reply_byte = p_addr_reg;
      else if (j == 8'd2)
        reply_byte = p_len_reg;
      else
        reply_byte = live_reg[k[2:0]];
    end
  endfunction

  assign mode_next = {~mode_select_high, ~mode_select_low};
  assign awake     = !reload_reg && (mode_reg == `MODE_NORMAL ||
                                     mode_reg == `MODE_WAKE);
  // fixed rate in config, stored rate else
  assign bit_len   = (mode_reg == `MODE_CONFIG) ?
                     bit_cycles(`BAUD_CFG_SEL) :
                     bit_cycles(live_reg[`SERIAL_REG][`BAUD_MSB:`BAUD_LSB]);
  // hold data back until the wake code is sent
  assign send_ok   = awake && (mode_reg == `MODE_NORMAL || !sender_reg ||
                               woken_reg);
  assign fifo_pop  = send_ok && (!radio_tx_valid || radio_tx_ready);
  assign rx_take   = radio_rx_ready && radio_rx_valid;
  assign cfg_rx    = rx_done_reg && mode_reg == `MODE_CONFIG &&
                     !reload_reg && !r_act_reg;
  assign span      = {1'b0, p_addr_reg} + {1'b0, rx_sh_reg};

  // host bytes wait here for the radio
  byte_fifo #(
    .WIDTH (8),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) host_to_radio (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (rx_done_reg && awake),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_sh_reg),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // mode tracking, reload sequencing and status pin
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_reg        <= `MODE_SLEEP;
      reload_reg      <= 1'b1;
      reload_idx_reg  <= 3'd0;
      status_ready    <= 1'b0;
      radio_tx_enable <= 1'b0;
      radio_rx_enable <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      // restart reload when sleep is left
      if (mode_reg == `MODE_SLEEP && mode_next != `MODE_SLEEP)
      begin
        reload_reg     <= 1'b1;
        reload_idx_reg <= 3'd0;
      end
      else if (reload_reg)
      begin
        reload_idx_reg <= reload_idx_reg + 3'd1;
        if (reload_idx_reg == 3'd7)
          reload_reg <= 1'b0;
      end
      // status low while reloading or asleep
      status_ready    <= !reload_reg && mode_reg != `MODE_SLEEP;
      // radio off in config and sleep
      radio_tx_enable <= awake;
      // receiver on in modes 0 and 1 once reload is done
      radio_rx_enable <= awake;
    end
  end

  // ahb-lite slave, zero wait, always okay
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      hrdata       <= 32'h0000_0000;
      ahb_wr_reg   <= 1'b0;
      ahb_addr_reg <= 8'h00;
      sender_reg   <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      // data phase of a write
      if (ahb_wr_reg && ahb_addr_reg == `OFS_CTRL)
        sender_reg <= hwdata[0];
      // address phase
      if (hready)
      begin
        ahb_wr_reg   <= hsel && htrans[1] && hwrite;
        ahb_addr_reg <= haddr[7:0];
        if (hsel && htrans[1] && !hwrite)
        begin
          case (haddr[7:0])
            `OFS_CTRL:      hrdata <= {31'h0, sender_reg};
            `OFS_STATUS:    hrdata <= {27'h0, fifo_out_valid,
                                       !fifo_in_ready, reload_reg,
                                       mode_reg};
            `OFS_CONFIG_LO: hrdata <= {live_reg[3], live_reg[2],
                                       live_reg[1], live_reg[0]};
            `OFS_CONFIG_HI: hrdata <= {live_reg[7], live_reg[6],
                                       live_reg[5], live_reg[4]};
            default:        hrdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // host serial receiver, mid-bit sampling
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rxd_prev_reg <= 1'b1;
      rx_busy_reg  <= 1'b0;
      rx_cnt_reg   <= 20'h0;
      rx_bit_reg   <= 4'h0;
      rx_sh_reg    <= 8'h00;
      rx_done_reg  <= 1'b0;
    end
    else
    begin
      rxd_prev_reg <= uart_rxd;
      rx_done_reg  <= 1'b0;
      if (!rx_busy_reg)
      begin
        // falling edge opens a frame
        if (rxd_prev_reg && !uart_rxd)
        begin
          rx_busy_reg <= 1'b1;
          rx_bit_reg  <= 4'h0;
          rx_cnt_reg  <= {1'b0, bit_len[19:1]};
        end
      end
      else if (rx_cnt_reg != 20'h0)
        rx_cnt_reg <= rx_cnt_reg - 20'h1;
      else
      begin
        rx_cnt_reg <= bit_len - 20'h1;
        if (rx_bit_reg == 4'h0 && uart_rxd)
          rx_busy_reg <= 1'b0;           // glitch, not a start bit
        else if (rx_bit_reg < 4'h9)
        begin
          if (rx_bit_reg != 4'h0)
            rx_sh_reg <= {uart_rxd, rx_sh_reg[7:1]};
          rx_bit_reg <= rx_bit_reg + 4'h1;
        end
        else
        begin
          rx_busy_reg <= 1'b0;
          rx_done_reg <= uart_rxd;       // framing error drops byte
        end
      end
    end
  end

  // host serial transmitter, fed by replies or radio data
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      uart_txd       <= 1'b1;
      tx_busy_reg    <= 1'b0;
      tx_cnt_reg     <= 20'h0;
      tx_bit_reg     <= 4'h0;
      tx_sh_reg      <= 10'h3ff;
      radio_rx_ready <= 1'b0;
    end
    else
    begin
      // take a radio byte only when the line is free
      radio_rx_ready <= awake && !tx_busy_reg && !rx_take;
      if (!tx_busy_reg)
      begin
        if (r_act_reg)
        begin
          tx_busy_reg <= 1'b1;
          tx_sh_reg   <= {1'b1, reply_byte(r_idx_reg), 1'b0};
          tx_bit_reg  <= 4'h0;
          tx_cnt_reg  <= 20'h0;
        end
        else if (rx_take)
        begin
          tx_busy_reg <= 1'b1;
          tx_sh_reg   <= {1'b1, radio_rx_data, 1'b0};
          tx_bit_reg  <= 4'h0;
          tx_cnt_reg  <= 20'h0;
        end
      end
      else if (tx_cnt_reg != 20'h0)
        tx_cnt_reg <= tx_cnt_reg - 20'h1;
      else if (tx_bit_reg == 4'ha)
      begin
        tx_busy_reg <= 1'b0;
        uart_txd    <= 1'b1;
      end
      else
      begin
        uart_txd   <= tx_sh_reg[0];
        tx_sh_reg  <= {1'b1, tx_sh_reg[9:1]};
        tx_bit_reg <= tx_bit_reg + 4'h1;
        tx_cnt_reg <= bit_len - 20'h1;
      end
    end
  end

  // radio send stage and wake-up preamble
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      radio_tx_data  <= 8'h00;
      radio_tx_valid <= 1'b0;
      radio_wake     <= 1'b0;
      woken_reg      <= 1'b0;
      wake_cnt_reg   <= 32'h0;
    end
    else
    begin
      // buffered host bytes go out on air
      if (fifo_pop)
      begin
        radio_tx_valid <= fifo_out_valid;
        radio_tx_data  <= fifo_out_data;
      end
      else if (!awake)
        radio_tx_valid <= 1'b0;
      // timed wake code before a burst
      if (!awake || mode_reg != `MODE_WAKE || !sender_reg)
      begin
        radio_wake   <= 1'b0;
        woken_reg    <= 1'b0;
        wake_cnt_reg <= 32'h0;
      end
      else if (!woken_reg && fifo_out_valid)
      begin
        radio_wake   <= 1'b1;
        wake_cnt_reg <= wake_cnt_reg + 32'h1;
        if (wake_cnt_reg == WAKE_CYCLES - 1)
        begin
          radio_wake <= 1'b0;
          woken_reg  <= 1'b1;
        end
      end
      else if (woken_reg && !fifo_out_valid && !radio_tx_valid)
      begin
        woken_reg    <= 1'b0;
        wake_cnt_reg <= 32'h0;
      end
    end
  end

  // command parser, reply sequencer and configuration store
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      p_state_reg <= P_IDLE;
      p_pfx_reg   <= 1'b0;
      p_cmd_reg   <= 8'h00;
      p_addr_reg  <= 8'h00;
      p_len_reg   <= 8'h00;
      p_cnt_reg   <= 8'h00;
      r_act_reg   <= 1'b0;
      r_err_reg   <= 1'b0;
      r_idx_reg   <= 8'h00;
      r_tot_reg   <= 8'h00;
      for (i = 0; i < `REG_COUNT; i = i + 1)
      begin
        live_reg[i] <= def_val(i[2:0]);
        save_reg[i] <= def_val(i[2:0]);
      end
    end
    else
    begin
      // copy kept values into the working set
      if (reload_reg)
        live_reg[reload_idx_reg] <= save_reg[reload_idx_reg];
      if (mode_reg != `MODE_CONFIG)
      begin
        p_state_reg <= P_IDLE;
        p_pfx_reg   <= 1'b0;
        r_act_reg   <= 1'b0;
      end
      else if (r_act_reg && !tx_busy_reg)
      begin
        // one reply byte per serial frame
        r_idx_reg <= r_idx_reg + 8'd1;
        if (r_idx_reg + 8'd1 == r_tot_reg)
        begin
          r_act_reg   <= 1'b0;
          p_state_reg <= P_IDLE;
          p_pfx_reg   <= 1'b0;
        end
      end
      else if (cfg_rx)
      begin
        case (p_state_reg)
          P_IDLE, P_HDR:
          begin
            // two prefix bytes mark a forwarded command
            if (rx_sh_reg == `CMD_PREFIX && p_state_reg == P_IDLE)
              p_state_reg <= P_PRE2;
            else if (rx_sh_reg == `CMD_WRITE || rx_sh_reg == `CMD_READ ||
                     rx_sh_reg == `CMD_TEMP)
            begin
              p_cmd_reg   <= rx_sh_reg;
              p_state_reg <= P_ADDR;
            end
            else
            begin
              // unknown header answered with error form
              r_act_reg   <= 1'b1;
              r_err_reg   <= 1'b1;
              r_idx_reg   <= 8'd0;
              r_tot_reg   <= p_pfx_reg ? `ERR_LEN + 8'd2 : `ERR_LEN;
              p_state_reg <= P_WAIT;
            end
          end
          P_PRE2:
          begin
            if (rx_sh_reg == `CMD_PREFIX)
            begin
              p_pfx_reg   <= 1'b1;
              p_state_reg <= P_HDR;
            end
            else
            begin
              r_act_reg   <= 1'b1;
              r_err_reg   <= 1'b1;
              r_idx_reg   <= 8'd0;
              r_tot_reg   <= `ERR_LEN;
              p_state_reg <= P_WAIT;
            end
          end
          P_ADDR:
          begin
            p_addr_reg  <= rx_sh_reg;
            p_state_reg <= P_LEN;
          end
          P_LEN:
          begin
            p_len_reg <= rx_sh_reg;
            p_cnt_reg <= 8'd0;
            r_idx_reg <= 8'd0;
            r_err_reg <= 1'b0;
            r_tot_reg <= rx_sh_reg + (p_pfx_reg ? 8'd5 : 8'd3);
            // empty or out-of-range span refused untouched
            if (rx_sh_reg == 8'd0 || span > `REG_COUNT_W)
            begin
              r_err_reg   <= 1'b1;
              r_act_reg   <= 1'b1;
              r_tot_reg   <= p_pfx_reg ? `ERR_LEN + 8'd2 : `ERR_LEN;
              p_state_reg <= P_WAIT;
            end
            // read replies at once from the live set
            else if (p_cmd_reg == `CMD_READ)
            begin
              r_act_reg   <= 1'b1;
              p_state_reg <= P_WAIT;
            end
            else
              p_state_reg <= P_DATA;
          end
          P_DATA:
          begin
            // temporary writes touch the live set only
            live_reg[p_addr_reg[2:0] + p_cnt_reg[2:0]] <= rx_sh_reg;
            if (p_cmd_reg == `CMD_WRITE)
              save_reg[p_addr_reg[2:0] + p_cnt_reg[2:0]] <= rx_sh_reg;
            p_cnt_reg <= p_cnt_reg + 8'd1;
            if (p_cnt_reg + 8'd1 == p_len_reg)
            begin
              r_act_reg   <= 1'b1;
              p_state_reg <= P_WAIT;
            end
          end
          default:
            p_state_reg <= P_WAIT;
        endcase
      end
    end
  end
endmodule // mode_select_config_commands
`default_nettype wire
